// ==== rtl/phy_ext_control_status_regs.sv ====
`timescale 1ns/1ps
module phy_ext_control_status_regs (
    input  wire logic                                clk_sys,
    input  wire logic                                reset,
    input  wire logic [phy_ext_regs_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                                s_axi_awvalid,
    output logic                                     s_axi_awready,
    input  wire logic [31:0]                         s_axi_wdata,
    input  wire logic [3:0]                          s_axi_wstrb,
    input  wire logic                                s_axi_wvalid,
    output logic                                     s_axi_wready,
    output logic [1:0]                               s_axi_bresp,
    output logic                                     s_axi_bvalid,
    input  wire logic                                s_axi_bready,
    input  wire logic [phy_ext_regs_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                                s_axi_arvalid,
    output logic                                     s_axi_arready,
    output logic [31:0]                              s_axi_rdata,
    output logic [1:0]                               s_axi_rresp,
    output logic                                     s_axi_rvalid,
    input  wire logic                                s_axi_rready,
    input  wire logic                                polarity_inverted_seen,
    input  wire logic                                self_test_err_byte,
    input  wire logic                                self_test_count_mode,
    input  wire logic                                self_test_ctrl_write,
    input  wire logic                                diag_done_in,
    input  wire logic                                diag_fail_in,
    input  wire logic [1:0]                          link_quality_in,
    output logic                                     rx_threshold_lower,
    output logic [3:0]                               squelch_level,
    output logic                                     link_pulse_suppress,
    output logic                                     jabber_suppress,
    output logic                                     polarity_flag,
    output logic [7:0]                               self_test_gap_bytes,
    output logic [10:0]                              self_test_pkt_bytes,
    output logic                                     diag_start,
    output logic                                     phy_soft_reset,
    output logic                                     phy_soft_restart
);

    logic [phy_ext_regs_pkg::ADDR_W-1:0] aw_addr;
    logic [31:0]                         w_data;
    logic [3:0]                          w_strb;
    logic                                aw_held;
    logic                                w_held;
    logic                                do_write;
    logic                                ar_fire;
    logic [7:0]                          w_idx;
    logic [7:0]                          r_idx;
    logic [15:0]                         wv;
    logic [15:0]                         w_cur;
    logic [7:0]                          err_run;
    logic [7:0]                          err_hold;
    logic                                err_frozen;
    logic                                done_q;
    logic                                fail_q;
    logic [1:0]                          quality_q;
    logic                                done_rise;
    logic                                wr_tbs;
    logic                                wr_errgap;
    logic                                wr_pktlen;
    logic                                wr_cdiag;
    logic                                wr_rstctl;

    ////////////////////////////////////////////////////////////////////////////
    // Decode and read view.

    function automatic logic [7:0] reg_idx(input logic [phy_ext_regs_pkg::ADDR_W-1:0] a);
        reg_idx = a[9:2];
    endfunction

    function automatic logic mapped(input logic [7:0] i);
        mapped = (i == phy_ext_regs_pkg::IDX_TBS) || (i == phy_ext_regs_pkg::IDX_ERRGAP)
              || (i == phy_ext_regs_pkg::IDX_PKTLEN) || (i == phy_ext_regs_pkg::IDX_CDIAG)
              || (i == phy_ext_regs_pkg::IDX_RSTCTL);
    endfunction

    // Reserved bits are never stored, so they read zero and ignore writes.
    function automatic logic [15:0] reg_view(input logic [7:0] i);
        reg_view = 16'h0000;
        unique case (i)
            phy_ext_regs_pkg::IDX_TBS:
            begin
                reg_view[phy_ext_regs_pkg::TBS_RXTH_BIT] = rx_threshold_lower;
                reg_view[phy_ext_regs_pkg::TBS_SQ_LSB +: 4] = squelch_level;
                reg_view[phy_ext_regs_pkg::TBS_NLP_BIT] = link_pulse_suppress;
                reg_view[phy_ext_regs_pkg::TBS_POL_BIT] = polarity_flag;
                reg_view[phy_ext_regs_pkg::TBS_JAB_BIT] = jabber_suppress;
            end
            phy_ext_regs_pkg::IDX_ERRGAP:
            begin
                reg_view[phy_ext_regs_pkg::ERR_LSB +: 8] = err_frozen ? err_hold : err_run;
                reg_view[7:0] = self_test_gap_bytes;
            end
            phy_ext_regs_pkg::IDX_PKTLEN:
                reg_view[10:0] = self_test_pkt_bytes;
            phy_ext_regs_pkg::IDX_CDIAG:
            begin
                reg_view[phy_ext_regs_pkg::CD_START_BIT] = diag_start;
                reg_view[phy_ext_regs_pkg::CD_LQ_LSB +: 2] = quality_q;
                reg_view[phy_ext_regs_pkg::CD_DONE_BIT] = done_q;
                reg_view[phy_ext_regs_pkg::CD_FAIL_BIT] = fail_q;
            end
            phy_ext_regs_pkg::IDX_RSTCTL:
            begin
                reg_view[phy_ext_regs_pkg::RST_SOFT_BIT] = phy_soft_reset;
                reg_view[phy_ext_regs_pkg::RST_RESTART] = phy_soft_restart;
            end
            default: reg_view = 16'h0000;
        endcase
    endfunction

    // Each 16-bit register is one word; lanes 0 and 1 carry it.
    assign w_idx     = reg_idx(aw_addr);
    assign r_idx     = reg_idx(s_axi_araddr);
    assign do_write  = aw_held && w_held && !s_axi_bvalid;
    assign ar_fire   = s_axi_arvalid && s_axi_arready;
    assign w_cur     = reg_view(w_idx);
    assign wv        = {w_strb[1] ? w_data[15:8] : w_cur[15:8],
                        w_strb[0] ? w_data[7:0] : w_cur[7:0]};
    assign wr_tbs    = do_write && (w_idx == phy_ext_regs_pkg::IDX_TBS);
    assign wr_errgap = do_write && (w_idx == phy_ext_regs_pkg::IDX_ERRGAP);
    assign wr_pktlen = do_write && (w_idx == phy_ext_regs_pkg::IDX_PKTLEN);
    assign wr_cdiag  = do_write && (w_idx == phy_ext_regs_pkg::IDX_CDIAG);
    assign wr_rstctl = do_write && (w_idx == phy_ext_regs_pkg::IDX_RSTCTL);
    assign done_rise = diag_done_in && !done_q;

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel.

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= '0;
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= phy_ext_regs_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held       <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(w_idx) ? phy_ext_regs_pkg::RESP_OKAY
                                              : phy_ext_regs_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                aw_held       <= 1'b0;
                w_held        <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel.

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= phy_ext_regs_pkg::RESP_OKAY;
        end
        else if (ar_fire)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {16'h0000, reg_view(r_idx)};
            s_axi_rresp   <= mapped(r_idx) ? phy_ext_regs_pkg::RESP_OKAY
                                           : phy_ext_regs_pkg::RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control fields; a software reset returns them to their reset values.

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset || phy_soft_reset)
        begin
            rx_threshold_lower  <= 1'b0;
            squelch_level       <= phy_ext_regs_pkg::SQUELCH_RST;
            link_pulse_suppress <= 1'b0;
            jabber_suppress     <= 1'b0;
            self_test_gap_bytes <= phy_ext_regs_pkg::GAP_RST;
            self_test_pkt_bytes <= phy_ext_regs_pkg::PKTLEN_RST;
        end
        else
        begin
            if (wr_tbs)
            begin
                rx_threshold_lower  <= wv[phy_ext_regs_pkg::TBS_RXTH_BIT];
                squelch_level       <= wv[phy_ext_regs_pkg::TBS_SQ_LSB +: 4];
                link_pulse_suppress <= wv[phy_ext_regs_pkg::TBS_NLP_BIT];
                jabber_suppress     <= wv[phy_ext_regs_pkg::TBS_JAB_BIT];
            end
            if (wr_errgap)
                self_test_gap_bytes <= wv[7:0];
            if (wr_pktlen)
                self_test_pkt_bytes <= wv[10:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset control bits are one-cycle pulses and read back as they stand.

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            phy_soft_reset   <= 1'b0;
            phy_soft_restart <= 1'b0;
        end
        else
        begin
            phy_soft_reset   <= wr_rstctl && wv[phy_ext_regs_pkg::RST_SOFT_BIT];
            phy_soft_restart <= wr_rstctl && wv[phy_ext_regs_pkg::RST_RESTART];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Polarity flag: one flop serves both copies; a new detection beats a read.

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset || phy_soft_reset)
            polarity_flag <= 1'b0;
        else if (polarity_inverted_seen)
            polarity_flag <= 1'b1;
        else if (ar_fire && (r_idx == phy_ext_regs_pkg::IDX_TBS))
            polarity_flag <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Self-test error counter with snapshot; the snapshot is released by reading it.

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset || phy_soft_reset)
        begin
            err_run    <= 8'h00;
            err_hold   <= 8'h00;
            err_frozen <= 1'b0;
        end
        else
        begin
            if (wr_errgap && wv[phy_ext_regs_pkg::ERR_CLR_BIT])
                err_run <= {7'h00, self_test_err_byte};
            else if (self_test_err_byte)
            begin
                if (!self_test_count_mode && err_run == phy_ext_regs_pkg::ERR_MAX)
                    err_run <= phy_ext_regs_pkg::ERR_MAX;
                else
                    err_run <= err_run + 8'h01;
            end
            if (self_test_ctrl_write || (wr_errgap && wv[phy_ext_regs_pkg::ERR_CLR_BIT]))
            begin
                err_hold   <= err_run;
                err_frozen <= 1'b1;
            end
            else if (ar_fire && (r_idx == phy_ext_regs_pkg::IDX_ERRGAP))
                err_frozen <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cable diagnostics.

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset || phy_soft_reset)
        begin
            done_q     <= 1'b0;
            fail_q     <= 1'b0;
            quality_q  <= 2'h0;
            diag_start <= 1'b0;
        end
        else
        begin
            done_q    <= diag_done_in;
            fail_q    <= diag_fail_in;
            quality_q <= link_quality_in;
            if (wr_cdiag && wv[phy_ext_regs_pkg::CD_START_BIT])
                diag_start <= 1'b1;
            else if (done_rise || wr_cdiag)
                diag_start <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_resv_zero;
        s_axi_rvalid && $past(ar_fire) && $past(r_idx) == phy_ext_regs_pkg::IDX_TBS
            |-> (s_axi_rdata & ~{16'h0000, phy_ext_regs_pkg::TBS_MASK}) == 32'h0;
    endproperty
    a_resv_zero: assert property (p_resv_zero) else $error("reserved bits set");

    property p_rxth;
        wr_tbs && w_strb[1] && !phy_soft_reset |=> rx_threshold_lower == $past(w_data[13]);
    endproperty
    a_rxth: assert property (p_rxth) else $error("threshold bit not written");

    property p_nlp;
        wr_tbs && w_strb[0] && !phy_soft_reset ##1 !wr_tbs && !phy_soft_reset
            |=> link_pulse_suppress == $past(w_data[7], 2);
    endproperty
    a_nlp: assert property (p_nlp) else $error("link pulse bit not held");

    property p_pol_clear;
        ar_fire && r_idx == phy_ext_regs_pkg::IDX_TBS && !polarity_inverted_seen
            |=> !polarity_flag;
    endproperty
    a_pol_clear: assert property (p_pol_clear) else $error("polarity not cleared");

    property p_saturate;
        !self_test_count_mode && err_run == 8'hff && !wr_errgap && !phy_soft_reset
            |=> err_run == 8'hff;
    endproperty
    a_saturate: assert property (p_saturate) else $error("counter wrapped");

    property p_clear_cnt;
        wr_errgap && wv[15] && !phy_soft_reset
            |=> err_run <= 8'h01 && err_frozen && err_hold == $past(err_run);
    endproperty
    a_clear_cnt: assert property (p_clear_cnt) else $error("capture or clear failed");

    property p_freeze;
        self_test_ctrl_write && !phy_soft_reset ##1 !self_test_ctrl_write && !wr_errgap
            && !(ar_fire && r_idx == phy_ext_regs_pkg::IDX_ERRGAP) && !phy_soft_reset
            |=> $stable(err_hold) && err_frozen;
    endproperty
    a_freeze: assert property (p_freeze) else $error("count not frozen");

    property p_start_clear;
        diag_start && diag_done_in && !done_q && !wr_cdiag |=> !diag_start;
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("start not cleared");

    property p_soft_reset;
        wr_rstctl && wv[15] |=> phy_soft_reset ##1 !phy_soft_reset && squelch_level == 4'h0
            && self_test_gap_bytes == 8'h7d && self_test_pkt_bytes == 11'h5dc;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset wrong");

    property p_restart_keep;
        phy_soft_restart && !phy_soft_reset |=> $stable(self_test_gap_bytes) || $past(wr_errgap);
    endproperty
    a_restart_keep: assert property (p_restart_keep) else $error("restart hit regs");

    property p_cov_write;
        do_write ##1 s_axi_bvalid && s_axi_bready;
    endproperty
    c_write: cover property (p_cov_write);

    property p_cov_sat;
        self_test_err_byte && err_run == 8'hff && !self_test_count_mode;
    endproperty
    c_sat: cover property (p_cov_sat);

    property p_cov_diag;
        diag_start ##[1:50] !diag_start && done_q;
    endproperty
    c_diag: cover property (p_cov_diag);

endmodule

// ==== rtl/phy_ext_regs_pkg.sv ====
package phy_ext_regs_pkg;

    // Management address map: register index, byte address is index times four.
    localparam int          ADDR_W        = 10;
    localparam logic [7:0]  IDX_TBS       = 8'h1a;
    localparam logic [7:0]  IDX_ERRGAP    = 8'h1b;
    localparam logic [7:0]  IDX_PKTLEN    = 8'h1c;
    localparam logic [7:0]  IDX_CDIAG     = 8'h1e;
    localparam logic [7:0]  IDX_RSTCTL    = 8'h1f;

    // Field positions.
    localparam int          TBS_RXTH_BIT  = 13;
    localparam int          TBS_SQ_LSB    = 9;
    localparam int          TBS_NLP_BIT   = 7;
    localparam int          TBS_POL_BIT   = 4;
    localparam int          TBS_JAB_BIT   = 0;
    localparam int          ERR_LSB       = 8;
    localparam int          ERR_CLR_BIT   = 15;
    localparam int          CD_START_BIT  = 15;
    localparam int          CD_LQ_LSB     = 8;
    localparam int          CD_DONE_BIT   = 1;
    localparam int          CD_FAIL_BIT   = 0;
    localparam int          RST_SOFT_BIT  = 15;
    localparam int          RST_RESTART   = 14;

    // Values after reset, and the saturation limit of the error counter.
    localparam logic [3:0]  SQUELCH_RST   = 4'h0;
    localparam logic [7:0]  GAP_RST       = 8'h7d;
    localparam logic [10:0] PKTLEN_RST    = 11'h5dc;
    localparam logic [7:0]  ERR_MAX       = 8'hff;

    // Bits of the TBS register that are implemented; all others read zero.
    localparam logic [15:0] TBS_MASK      = 16'h3e91;

    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage

// ==== test/diag_engine_model.sv ====
`timescale 1ns/1ps
// Stands in for the cable diagnostic engine behind the register group.
module diag_engine_model #(
    parameter int LAT = 6
) (
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       diag_start,
    input  wire logic       fail_cfg,
    input  wire logic [1:0] qual_cfg,
    output logic            diag_done_in,
    output logic            diag_fail_in,
    output logic [1:0]      link_quality_in
);
    logic       start_q;
    logic [7:0] cnt;

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            start_q <= 1'b0;
            cnt <= 8'h00;
            diag_done_in <= 1'b0;
        end
        else
        begin
            start_q <= diag_start;
            if (diag_start && !start_q)
            begin
                cnt <= 8'h00;
                diag_done_in <= 1'b0;
            end
            else if (diag_start && cnt == 8'(LAT))
                diag_done_in <= 1'b1;
            else if (diag_start)
                cnt <= cnt + 8'h01;
        end
    end

    // Quality is only presented once a measurement has finished.
    assign diag_fail_in    = diag_done_in & fail_cfg;
    assign link_quality_in = diag_done_in ? qual_cfg : 2'h0;
endmodule

// ==== test/phy_ext_control_status_regs_tb.sv ====
`timescale 1ns/1ps
module phy_ext_control_status_regs_tb;
    localparam logic [7:0] TBS = phy_ext_regs_pkg::IDX_TBS;
    localparam logic [7:0] EGP = phy_ext_regs_pkg::IDX_ERRGAP;
    localparam logic [7:0] PLN = phy_ext_regs_pkg::IDX_PKTLEN;
    localparam logic [7:0] CDG = phy_ext_regs_pkg::IDX_CDIAG;
    localparam logic [7:0] RST = phy_ext_regs_pkg::IDX_RSTCTL;
    logic clk_sys = 1'b0, reset = 1'b1;
    logic [phy_ext_regs_pkg::ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, polarity_inverted_seen = 0, self_test_err_byte = 0;
    logic self_test_count_mode = 0, self_test_ctrl_write = 0, fail_cfg = 0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, r, d;
    logic [3:0] s_axi_wstrb = '0, squelch_level;
    logic [1:0] s_axi_bresp, s_axi_rresp, link_quality_in, rs, qual_cfg = 2'h1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic diag_done_in, diag_fail_in, rx_threshold_lower, link_pulse_suppress;
    logic jabber_suppress, polarity_flag, diag_start, phy_soft_reset, phy_soft_restart;
    logic [7:0] self_test_gap_bytes, g;
    logic [10:0] self_test_pkt_bytes, pe;
    int n_errors = 0, checks_done = 0, n_srst = 0, n_rstr = 0, i, k;

    phy_ext_control_status_regs phy_ext_control_status_regs_inst (.clk_sys, .reset,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .polarity_inverted_seen, .self_test_err_byte,
        .self_test_count_mode, .self_test_ctrl_write, .diag_done_in, .diag_fail_in,
        .link_quality_in, .rx_threshold_lower, .squelch_level, .link_pulse_suppress,
        .jabber_suppress, .polarity_flag, .self_test_gap_bytes, .self_test_pkt_bytes,
        .diag_start, .phy_soft_reset, .phy_soft_restart);
    diag_engine_model diag_engine_model_inst (.clk_sys, .reset, .diag_start, .fail_cfg,
        .qual_cfg, .diag_done_in, .diag_fail_in, .link_quality_in);

    initial forever #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        if (phy_soft_reset === 1'b1) n_srst++;
        if (phy_soft_restart === 1'b1) n_rstr++;
    end
    initial
    begin
        #1000000;
        fail_wait();
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic fail_wait();
        n_errors++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        give_verdict();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Write one word; address and data are released each at its own handshake.
    task automatic wr(input logic [7:0] idx, input logic [15:0] v, input logic [3:0] st,
                      input logic [1:0] er);
        @(posedge clk_sys);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {16'h0000, v};
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 50 && s_axi_bvalid !== 1'b1; i++)
        begin
            @(posedge clk_sys);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end
        if (i == 50) fail_wait();
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er));
    endtask
    task automatic rd(input logic [7:0] idx, output logic [31:0] v, output logic [1:0] e);
        @(posedge clk_sys);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 50 && s_axi_rvalid !== 1'b1; i++)
        begin
            @(posedge clk_sys);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end
        if (i == 50) fail_wait();
        v = s_axi_rdata;
        e = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] idx, input logic [15:0] e);
        rd(idx, r, rs);
        chk(r, {16'h0000, e});
        chk(32'(rs), 32'(phy_ext_regs_pkg::RESP_OKAY));
    endtask
    task automatic pulse_err(input int n);
        repeat (n)
        begin
            @(posedge clk_sys);
            self_test_err_byte <= 1'b1;
            @(posedge clk_sys);
            self_test_err_byte <= 1'b0;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(13));
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        rchk(TBS, 16'h0000);
        rchk(EGP, 16'h007d);
        rchk(PLN, 16'h05dc);
        rchk(CDG, 16'h0000);
        rchk(RST, 16'h0000);
        for (k = 0; k < 8; k++)
        begin
            d = (k == 0) ? 32'hffffffff : $urandom;
            wr(TBS, d[15:0], 4'h3, phy_ext_regs_pkg::RESP_OKAY);
            rchk(TBS, d[15:0] & 16'h3e81);
            chk({rx_threshold_lower, squelch_level, link_pulse_suppress, jabber_suppress},
                {d[13], d[12:9], d[7], d[0]});
            wr(PLN, d[31:16], 4'h3, phy_ext_regs_pkg::RESP_OKAY);
            rchk(PLN, {5'h00, d[26:16]});
            chk(32'(self_test_pkt_bytes), 32'(d[26:16]));
        end
        pe = {d[26:24], 8'hff};
        wr(PLN, 16'hffff, 4'h1, phy_ext_regs_pkg::RESP_OKAY);
        rchk(PLN, {5'h00, pe});
        polarity_inverted_seen <= 1'b1;
        @(posedge clk_sys);
        polarity_inverted_seen <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(32'(polarity_flag), 32'h1);
        rchk(TBS, (d[15:0] & 16'h3e81) | 16'h0010);
        chk(32'(polarity_flag), 32'h0);
        rchk(TBS, d[15:0] & 16'h3e81);
        g = 8'($urandom);
        wr(EGP, {8'h80, g}, 4'h3, phy_ext_regs_pkg::RESP_OKAY);
        chk(32'(self_test_gap_bytes), 32'(g));
        rchk(EGP, {8'h00, g});
        pulse_err(300);
        rchk(EGP, {8'hff, g});
        self_test_count_mode <= 1'b1;
        wr(EGP, {8'h80, g}, 4'h3, phy_ext_regs_pkg::RESP_OKAY);
        pulse_err(258);
        rchk(EGP, {8'hff, g});
        rchk(EGP, {8'h02, g});
        self_test_ctrl_write <= 1'b1;
        @(posedge clk_sys);
        self_test_ctrl_write <= 1'b0;
        pulse_err(3);
        rchk(EGP, {8'h02, g});
        rchk(EGP, {8'h05, g});
        for (k = 0; k < 3; k++)
        begin
            fail_cfg <= k[0];
            qual_cfg <= 2'(k + 1);
            wr(CDG, 16'h8000, 4'h3, phy_ext_regs_pkg::RESP_OKAY);
            chk(32'(diag_start), 32'h1);
            for (i = 0; i < 50 && diag_start !== 1'b0; i++) @(posedge clk_sys);
            if (i == 50) fail_wait();
            repeat (2) @(posedge clk_sys);
            rchk(CDG, {6'h00, 2'(k + 1), 7'h01, k[0]});
        end
        wr(RST, 16'h4000, 4'h3, phy_ext_regs_pkg::RESP_OKAY);
        repeat (4) @(posedge clk_sys);
        chk(32'(n_rstr), 32'h1);
        rchk(PLN, {5'h00, pe});
        rchk(RST, 16'h0000);
        wr(RST, 16'h8000, 4'h3, phy_ext_regs_pkg::RESP_OKAY);
        repeat (4) @(posedge clk_sys);
        chk(32'(n_srst), 32'h1);
        rchk(PLN, 16'h05dc);
        rchk(TBS, 16'h0000);
        chk(32'(self_test_gap_bytes), 32'h7d);
        wr(8'h1d, 16'hffff, 4'h3, phy_ext_regs_pkg::RESP_SLVERR);
        rd(8'h1d, r, rs);
        chk(r, 32'h0);
        chk(32'(rs), 32'(phy_ext_regs_pkg::RESP_SLVERR));
        give_verdict();
    end
endmodule
